// ===== uq_pkg.sv
// shared constants and state codes for the four-channel uart block
// assumes a single 200 MHz system clock and synchronous active-high reset
`default_nettype none

package uq_pkg;

	localparam int CHANNELS    = 4;
	localparam int DATA_W      = 8;
	localparam int FIFO_DEPTH  = 16;

	// serial bit time, 1 Mbit/s line rate by default
	localparam int CLK_MHZ     = 200;
	localparam int BIT_TIME_NS = 1000;
	localparam int BIT_CYCLES  = (BIT_TIME_NS * CLK_MHZ) / 1000;
	localparam int CYC_W       = 16;
	localparam int FRAME_BITS  = 10;
	localparam int BITN_W      = 4;

	localparam logic LINE_IDLE = 1'b1;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} uq_rx_state_e;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h1,
		TX_SEND = 2'h2
	} uq_tx_state_e;

endpackage : uq_pkg

`default_nettype wire

// ===== uq_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes same clock on both sides; depth must be a power of two
`default_nettype none
`timescale 1ns/100ps

module uq_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);

	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("uq_fifo: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;
	logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;
	logic [AW:0]      count_r, count_nxt;
	logic             push, pop;

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_ptr_r];
	assign level     = count_r;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
		rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
		count_nxt  = count_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

	// storage cleared as well, so the read data port shows zero after reset
	always_ff @(posedge sys_clk) begin
		if (reset)
			mem_r <= '{default: '0};
		else if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

endmodule // uq_fifo

`default_nettype wire

// ===== uq_quad_uart.sv
// four uart channels with shared active-low ready pins and local loop-back
// assumes host-side strobes are on sys_clk; serial inputs are asynchronous
`default_nettype none
`timescale 1ns/100ps

// How it works
// - transmit pin rests high in reset, idle, disabled after current frame
// - loop-back disables pin, feeds transmit into receiver
// - loop-back ignores external receive pin
// - shared receive pin low when any data held
// - shared receive pin high once all empty
// - shared transmit pin low when any space
// - shared transmit pin high only when all full
// - per-channel receive status readable by host
// - per-channel transmit status readable by host
// - reset clears state, outputs, disables serial paths
module uq_quad_uart
	import uq_pkg::*;
#(
	parameter int CH       = uq_pkg::CHANNELS,
	parameter int DEPTH    = uq_pkg::FIFO_DEPTH,
	parameter int BIT_CYC  = uq_pkg::BIT_CYCLES
) (
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          reset,
	// per-channel control
	input  wire logic [CH-1:0]                 tx_enable,
	input  wire logic [CH-1:0]                 loopback,
	// host write side, into transmit fifos
	input  wire logic [CH-1:0]                 tx_wr_valid,
	output logic      [CH-1:0]                 tx_wr_ready,
	input  wire logic [CH-1:0][uq_pkg::DATA_W-1:0] tx_wr_data,
	// host read side, out of receive fifos
	output logic      [CH-1:0]                 rx_rd_valid,
	input  wire logic [CH-1:0]                 rx_rd_ready,
	output logic      [CH-1:0][uq_pkg::DATA_W-1:0] rx_rd_data,
	// per-channel status
	output logic      [CH-1:0]                 receive_avail_per_channel,
	output logic      [CH-1:0]                 transmit_space_per_channel,
	output logic      [CH-1:0]                 tx_busy,
	output logic      [CH-1:0]                 rx_overrun,
	output logic      [CH-1:0]                 rx_frame_err,
	// shared ready pins, active low
	output logic                               receive_avail_n_shared,
	output logic                               transmit_space_n_shared,
	// serial line
	input  wire logic [CH-1:0]                 serial_in_per_channel,
	output logic      [CH-1:0]                 serial_out_per_channel
);

	import uq_pkg::*;

	initial begin
		if (BIT_CYC < 4 || BIT_CYC >= (1 << CYC_W) || CH < 1 || DEPTH != FIFO_DEPTH)
			$error("uq_quad_uart: unsupported parameter value");
	end

	localparam logic [CYC_W-1:0] BIT_LAST  = CYC_W'(BIT_CYC - 1);
	localparam logic [CYC_W-1:0] HALF_LAST = CYC_W'(BIT_CYC / 2 - 1);

	////////////////////////////////////////////////////////////////////
	// shared active-low ready pins

	assign receive_avail_n_shared  = ~|receive_avail_per_channel;
	assign transmit_space_n_shared = ~|transmit_space_per_channel;

	////////////////////////////////////////////////////////////////////
	// channels

	for (genvar c = 0; c < CH; c++) begin : g_ch
		logic               txf_valid, txf_ready;
		logic [DATA_W-1:0]  txf_data;
		logic               rxf_push_r, rxf_push_nxt, rxf_ready;
		logic [DATA_W-1:0]  rxf_data_r, rxf_data_nxt;

		uq_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_txf (
			.sys_clk   (sys_clk),
			.reset     (reset),
			.in_valid  (tx_wr_valid[c]),
			.in_ready  (tx_wr_ready[c]),
			.in_data   (tx_wr_data[c]),
			.out_valid (txf_valid),
			.out_ready (txf_ready),
			.out_data  (txf_data),
			.level     ()
		);

		// a full receive fifo drops the new character and flags overrun
		uq_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rxf (
			.sys_clk   (sys_clk),
			.reset     (reset),
			.in_valid  (rxf_push_r),
			.in_ready  (rxf_ready),
			.in_data   (rxf_data_r),
			.out_valid (rx_rd_valid[c]),
			.out_ready (rx_rd_ready[c]),
			.out_data  (rx_rd_data[c]),
			.level     ()
		);

		assign receive_avail_per_channel[c]  = rx_rd_valid[c];
		assign transmit_space_per_channel[c] = tx_wr_ready[c];

		////////////////////////////////////////////////////////////
		// transmitter

		uq_tx_state_e                tx_st_r, tx_st_nxt;
		logic [CYC_W-1:0]            tx_cyc_r, tx_cyc_nxt;
		logic [BITN_W-1:0]           tx_bitn_r, tx_bitn_nxt;
		logic [FRAME_BITS-1:0]       tx_sh_r, tx_sh_nxt;
		logic                        tx_line_r, tx_line_nxt;
		logic                        pin_r, pin_nxt;

		// transmitter only pulls a character while enabled and idle
		assign txf_ready  = (tx_st_r == TX_IDLE) && tx_enable[c];
		assign tx_busy[c] = (tx_st_r == TX_SEND);

		always_comb begin
			tx_st_nxt   = tx_st_r;
			tx_cyc_nxt  = tx_cyc_r;
			tx_bitn_nxt = tx_bitn_r;
			tx_sh_nxt   = tx_sh_r;
			case (tx_st_r)
				TX_IDLE: begin
					if (txf_valid && txf_ready) begin
						tx_sh_nxt   = {LINE_IDLE, txf_data, 1'b0};
						tx_cyc_nxt  = BIT_LAST;
						tx_bitn_nxt = BITN_W'(FRAME_BITS - 1);
						tx_st_nxt   = TX_SEND;
					end
				end
				TX_SEND: begin
					if (tx_cyc_r == '0) begin
						tx_sh_nxt  = {LINE_IDLE, tx_sh_r[FRAME_BITS-1:1]};
						tx_cyc_nxt = BIT_LAST;
						if (tx_bitn_r == '0)
							tx_st_nxt = TX_IDLE;
						else
							tx_bitn_nxt = tx_bitn_r - 1'b1;
					end else begin
						tx_cyc_nxt = tx_cyc_r - 1'b1;
					end
				end
				default: tx_st_nxt = TX_IDLE;
			endcase
			// idle transmitter rests high; disabling does not cut a frame short
			tx_line_nxt = (tx_st_nxt == TX_SEND) ? tx_sh_nxt[0] : LINE_IDLE;
			// loop-back keeps the pin at rest while data loops inside
			pin_nxt     = loopback[c] ? LINE_IDLE : tx_line_nxt;
		end

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				tx_st_r   <= TX_IDLE;
				tx_cyc_r  <= '0;
				tx_bitn_r <= '0;
				tx_sh_r   <= '1;
				tx_line_r <= LINE_IDLE;
				pin_r     <= LINE_IDLE;
			end else begin
				tx_st_r   <= tx_st_nxt;
				tx_cyc_r  <= tx_cyc_nxt;
				tx_bitn_r <= tx_bitn_nxt;
				tx_sh_r   <= tx_sh_nxt;
				tx_line_r <= tx_line_nxt;
				pin_r     <= pin_nxt;
			end
		end

		assign serial_out_per_channel[c] = pin_r;

		////////////////////////////////////////////////////////////
		// receiver

		logic              sync1_r, sync2_r;
		logic              rx_line;
		uq_rx_state_e      rx_st_r, rx_st_nxt;
		logic [CYC_W-1:0]  rx_cyc_r, rx_cyc_nxt;
		logic [BITN_W-1:0] rx_bitn_r, rx_bitn_nxt;
		logic [DATA_W-1:0] rx_sh_r, rx_sh_nxt;
		logic              ovr_r, ovr_nxt;
		logic              ferr_r, ferr_nxt;

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				sync1_r <= LINE_IDLE;
				sync2_r <= LINE_IDLE;
			end else begin
				sync1_r <= serial_in_per_channel[c];
				sync2_r <= sync1_r;
			end
		end

		// loop-back reads the transmit stream and ignores the pin
		assign rx_line = loopback[c] ? tx_line_r : sync2_r;

		always_comb begin
			rx_st_nxt    = rx_st_r;
			rx_cyc_nxt   = rx_cyc_r;
			rx_bitn_nxt  = rx_bitn_r;
			rx_sh_nxt    = rx_sh_r;
			rxf_push_nxt = 1'b0;
			rxf_data_nxt = rxf_data_r;
			ferr_nxt     = 1'b0;
			ovr_nxt      = rxf_push_r && !rxf_ready;
			case (rx_st_r)
				RX_IDLE: begin
					if (!rx_line) begin
						rx_cyc_nxt = HALF_LAST;
						rx_st_nxt  = RX_START;
					end
				end
				RX_START: begin
					if (rx_cyc_r != '0)
						rx_cyc_nxt = rx_cyc_r - 1'b1;
					else if (rx_line)
						rx_st_nxt = RX_IDLE; // false start, glitch only
					else begin
						rx_cyc_nxt  = BIT_LAST;
						rx_bitn_nxt = '0;
						rx_st_nxt   = RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_cyc_r != '0)
						rx_cyc_nxt = rx_cyc_r - 1'b1;
					else begin
						rx_sh_nxt  = {rx_line, rx_sh_r[DATA_W-1:1]};
						rx_cyc_nxt = BIT_LAST;
						if (rx_bitn_r == BITN_W'(DATA_W - 1))
							rx_st_nxt = RX_STOP;
						else
							rx_bitn_nxt = rx_bitn_r + 1'b1;
					end
				end
				RX_STOP: begin
					if (rx_cyc_r != '0)
						rx_cyc_nxt = rx_cyc_r - 1'b1;
					else begin
						rxf_push_nxt = rx_line;
						rxf_data_nxt = rx_sh_r;
						ferr_nxt     = !rx_line;
						rx_st_nxt    = RX_IDLE;
					end
				end
				default: rx_st_nxt = RX_IDLE;
			endcase
		end

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				rx_st_r    <= RX_IDLE;
				rx_cyc_r   <= '0;
				rx_bitn_r  <= '0;
				rx_sh_r    <= '0;
				rxf_push_r <= 1'b0;
				rxf_data_r <= '0;
				ovr_r      <= 1'b0;
				ferr_r     <= 1'b0;
			end else begin
				rx_st_r    <= rx_st_nxt;
				rx_cyc_r   <= rx_cyc_nxt;
				rx_bitn_r  <= rx_bitn_nxt;
				rx_sh_r    <= rx_sh_nxt;
				rxf_push_r <= rxf_push_nxt;
				rxf_data_r <= rxf_data_nxt;
				ovr_r      <= ovr_nxt;
				ferr_r     <= ferr_nxt;
			end
		end

		assign rx_overrun[c]   = ovr_r;
		assign rx_frame_err[c] = ferr_r;
	end

endmodule // uq_quad_uart

`default_nettype wire

// ===== uq_line_model.sv
// far-end serial sender for the four receive lines
// assumes sys_clk timing and 8N1 frames of BIT_CYC cycles per bit
`timescale 1ns/100ps
`default_nettype none
module uq_line_model #(
	parameter int BIT_CYC = 8
) (
	// clock
	input  wire logic       sys_clk,
	// toggle the lines, only while they must be ignored
	input  wire logic       noise,
	// lines toward the block
	output logic      [3:0] line
);
	logic [3:0] drv = 4'hf;
	logic       flip = 1'b0;
	////////////////////////////////////////
	always @(posedge sys_clk) begin
		flip <= ~flip;
	end
	// idle and stop level is high
	assign line = noise ? {4{flip}} : drv;
	task automatic send(input int ch, input logic [7:0] b, input logic stop);
		logic [9:0] fr;
		fr = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk);
			drv[ch] <= fr[i];
			repeat (BIT_CYC - 1) @(posedge sys_clk);
		end
		// a low stop bit must not leave the line held low
		@(posedge sys_clk);
		drv[ch] <= 1'b1;
	endtask
endmodule // uq_line_model
`default_nettype wire

// ===== uq_quad_uart_chk.sv
// pin assertions for the four-channel uart
// assumes binding onto uq_quad_uart, single clock
`timescale 1ns/100ps
`default_nettype none
module uq_quad_uart_chk #(
	parameter int CH = 4
) (
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          reset,
	// watched pins
	input  wire logic [CH-1:0] tx_enable,
	input  wire logic [CH-1:0] loopback,
	input  wire logic [CH-1:0] tx_wr_valid,
	input  wire logic [CH-1:0] tx_wr_ready,
	input  wire logic [CH-1:0] rx_rd_valid,
	input  wire logic [CH-1:0] rx_rd_ready,
	input  wire logic [CH-1:0] receive_avail_per_channel,
	input  wire logic [CH-1:0] transmit_space_per_channel,
	input  wire logic [CH-1:0] tx_busy,
	input  wire logic          receive_avail_n_shared,
	input  wire logic          transmit_space_n_shared,
	input  wire logic [CH-1:0] serial_out_per_channel
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	a_tx_rest_high: assert property (&(serial_out_per_channel | tx_busy))
		else $error("serial out low outside a frame");
	a_no_start_off: assert property ((tx_busy & ~$past(tx_busy) & ~$past(tx_enable)) == '0)
		else $error("frame started while disabled");
	a_loop_pin_high: assert property (&(serial_out_per_channel | ~(loopback & $past(loopback))))
		else $error("serial out moves in loop-back");
	a_rx_shared_or: assert property (receive_avail_n_shared == !(|receive_avail_per_channel))
		else $error("shared receive pin wrong");
	a_tx_shared_or: assert property (transmit_space_n_shared == !(|transmit_space_per_channel))
		else $error("shared transmit pin wrong");
	// status may only drop when the host has read or written a byte
	a_rx_status_match: assert property (receive_avail_per_channel == rx_rd_valid
		&& (~receive_avail_per_channel & $past(receive_avail_per_channel & ~rx_rd_ready)) == '0)
		else $error("receive status differs or dropped unread");
	a_tx_status_match: assert property (transmit_space_per_channel == tx_wr_ready
		&& (~transmit_space_per_channel & $past(transmit_space_per_channel & ~tx_wr_valid)) == '0)
		else $error("transmit status differs or dropped unwritten");
	// reset itself is the cause here, so no disable
	a_reset_clears: assert property (disable iff (1'b0) reset |=> (&serial_out_per_channel
		&& tx_busy == '0 && rx_rd_valid == '0 && &tx_wr_ready))
		else $error("reset left state behind");
endmodule // uq_quad_uart_chk
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the four-channel uart
// assumes uq_pkg, uq_quad_uart, line model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import uq_pkg::*;
	localparam int BC = 8;
	logic            sys_clk = 1'b0;
	logic            reset = 1'b1;
	logic            noise = 1'b0;
	logic [3:0]      tx_enable = '0, loopback = '0, tx_wr_valid = '0, rx_rd_ready = '0;
	logic [3:0][7:0] tx_wr_data = '0;
	logic [3:0][7:0] rx_rd_data;
	logic [3:0]      tx_wr_ready, rx_rd_valid, ra, ts, tx_busy, serial_out, line, ovr, ferr;
	logic            ra_n, ts_n;
	int              n_fail = 0, checked = 0;
	////////////////////////////////////////
	uq_quad_uart #(.BIT_CYC(BC)) DUT (.sys_clk(sys_clk), .reset(reset),
		.tx_enable(tx_enable), .loopback(loopback), .tx_wr_valid(tx_wr_valid),
		.tx_wr_ready(tx_wr_ready), .tx_wr_data(tx_wr_data), .rx_rd_valid(rx_rd_valid),
		.rx_rd_ready(rx_rd_ready), .rx_rd_data(rx_rd_data), .receive_avail_per_channel(ra),
		.transmit_space_per_channel(ts), .tx_busy(tx_busy), .rx_overrun(ovr), .rx_frame_err(ferr),
		.receive_avail_n_shared(ra_n), .transmit_space_n_shared(ts_n),
		.serial_in_per_channel(line), .serial_out_per_channel(serial_out));
	uq_line_model #(.BIT_CYC(BC)) LINE (.sys_clk(sys_clk), .noise(noise), .line(line));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input int c, input logic [7:0] d);
		@(posedge sys_clk);
		tx_wr_valid[c] <= 1'b1;
		tx_wr_data[c] <= d;
		do @(posedge sys_clk); while (!tx_wr_ready[c]);
		tx_wr_valid[c] <= 1'b0;
	endtask
	task automatic rd(input int c, output logic [7:0] d);
		do @(posedge sys_clk); while (!rx_rd_valid[c]);
		rx_rd_ready[c] <= 1'b1;
		@(posedge sys_clk);
		d = rx_rd_data[c];
		rx_rd_ready[c] <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		chk("tx_idle", serial_out, 4'hf);
		chk("space_n", ts_n, 1'b0);
		chk("avail_n", ra_n, 1'b1);
		chk("rd_data", rx_rd_data, 32'h0);
		reset <= 1'b0;
	endtask
	task automatic t_fill();
		for (int c = 0; c < 4; c++) begin
			chk("space_n", ts_n, 1'b0);
			for (int i = 0; i < 16; i++)
				wr(c, 8'(c * 16 + i));
			@(posedge sys_clk);
			chk("space", ts[c], 1'b0);
		end
		chk("space_n", ts_n, 1'b1);
		chk("tx_idle", serial_out, 4'hf);
	endtask
	// external lines toggle the whole time, receivers must not see it
	task automatic t_loop();
		logic [7:0] d;
		int         k;
		@(posedge sys_clk);
		noise <= 1'b1;
		loopback <= 4'hf;
		tx_enable <= 4'hf;
		repeat (16 * (10 * BC + 4)) @(posedge sys_clk);
		chk("avail_n", ra_n, 1'b0);
		chk("line_out", serial_out, 4'hf);
		// a seventeenth character finds the receive fifo full and is dropped
		wr(0, 8'h77);
		k = 0;
		while (!ovr[0] && k < 10 * BC + 8) begin
			@(posedge sys_clk);
			k++;
		end
		chk("overrun", ovr, 4'h1);
		for (int c = 0; c < 4; c++)
			for (int i = 0; i < 16; i++) begin
				rd(c, d);
				chk("loop_data", d, 8'(c * 16 + i));
			end
		@(posedge sys_clk);
		chk("avail_n", ra_n, 1'b1);
		noise <= 1'b0;
		tx_enable <= 4'h0;
		repeat (4) @(posedge sys_clk);
		loopback <= 4'h0;
	endtask
	task automatic t_line_rx();
		logic [7:0] d;
		LINE.send(2, 8'h3c, 1'b1);
		repeat (BC) @(posedge sys_clk);
		chk("avail", ra, 4'h4);
		chk("avail_n", ra_n, 1'b0);
		rd(2, d);
		chk("line_data", d, 8'h3c);
		@(posedge sys_clk);
		chk("avail_n", ra_n, 1'b1);
		// low stop bit: flagged, nothing stored, trailing low is a false start
		LINE.send(2, 8'hc3, 1'b0);
		chk("frame_err", ferr, 4'h4);
		repeat (2 * BC) @(posedge sys_clk);
		chk("avail_n", ra_n, 1'b1);
	endtask
	// reset in mid-run must empty the full transmit fifo of channel 3 again
	task automatic t_reset_mid();
		for (int i = 0; i < 16; i++)
			wr(3, 8'(i));
		@(posedge sys_clk);
		chk("space", ts[3], 1'b0);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		chk("space", ts, 4'hf);
		chk("avail_n", ra_n, 1'b1);
		chk("rd_data", rx_rd_data, 32'h0);
		chk("tx_idle", serial_out, 4'hf);
	endtask
	task automatic t_tx_frame();
		logic [9:0] fr;
		fr = {1'b1, 8'ha5, 1'b0};
		@(posedge sys_clk);
		tx_enable <= 4'h2;
		wr(1, 8'ha5);
		do @(posedge sys_clk); while (serial_out[1]);
		repeat (BC / 2) @(posedge sys_clk);
		for (int i = 0; i < 10; i++) begin
			chk("tx_bit", serial_out[1], fr[i]);
			repeat (BC) @(posedge sys_clk);
		end
		tx_enable <= 4'h0;
		wr(1, 8'h5a);
		repeat (3 * BC) @(posedge sys_clk);
		chk("tx_off", {tx_busy[1], serial_out[1]}, 2'b01);
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		t_reset();
		t_fill();
		t_loop();
		t_line_rx();
		t_tx_frame();
		t_reset_mid();
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		print_verdict();
	end
endmodule // tb_top
bind uq_quad_uart uq_quad_uart_chk #(.CH(CH)) CHK (.sys_clk(sys_clk), .reset(reset),
	.tx_enable(tx_enable), .loopback(loopback), .tx_wr_valid(tx_wr_valid),
	.tx_wr_ready(tx_wr_ready), .rx_rd_ready(rx_rd_ready),
	.rx_rd_valid(rx_rd_valid), .receive_avail_per_channel(receive_avail_per_channel),
	.transmit_space_per_channel(transmit_space_per_channel), .tx_busy(tx_busy),
	.receive_avail_n_shared(receive_avail_n_shared),
	.transmit_space_n_shared(transmit_space_n_shared),
	.serial_out_per_channel(serial_out_per_channel));
`default_nettype wire
